// *** design/ffia_pkg.sv ***
// package: register map, field layout and bus types of the fault flag interrupt aggregator
package ffia_pkg;
  // ****************************************
  // register offsets (printed offsets are not all multiples of four: index * 4)
  // ****************************************
  localparam logic [7:0] IDX_LIVE_A = 8'h0c;
  localparam logic [7:0] IDX_LIVE_B = 8'h0d;
  localparam logic [7:0] IDX_FLAG_A = 8'h11;
  localparam logic [7:0] IDX_FLAG_B = 8'h12;
  localparam logic [7:0] IDX_MASK_A = 8'h17;
  localparam logic [7:0] IDX_MASK_B = 8'h18;
  localparam logic [7:0] IDX_EVT_STAT = 8'h20;
  localparam logic [7:0] IDX_EVT_CLR = 8'h21;
  localparam logic [7:0] IDX_EVT_EN = 8'h22;
  localparam int ADDR_W = 10;
  // ****************************************
  // field layout
  // ****************************************
  localparam logic [7:0] FLAG_A_BITS = 8'h2f;
  localparam logic [7:0] FLAG_B_BITS = 8'h0f;
  localparam logic [7:0] MASK_A_RST = 8'h00;
  localparam logic [7:0] MASK_B_RST = 8'h00;
  localparam logic [7:0] FLAG_RST = 8'h00;
  localparam logic [1:0] EVT_BITS = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0] grp_a;
    logic [7:0] grp_b;
  } ffia_flags_t;

  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
  } ffia_addr_t;
endpackage : ffia_pkg

// *** design/ffia_flag_bank.sv ***
// module: one bank of sticky flags with write-zero-to-clear
`timescale 1ns/1ps
module ffia_flag_bank #(
  parameter int WIDTH = 8,
  parameter logic [7:0] IMPL = 8'hff
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] live,
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [WIDTH-1:0] wr_strb,
  output logic [WIDTH-1:0] flags
);
  logic [WIDTH-1:0] flags_ff;
  logic [WIDTH-1:0] nxt_flags;
  logic [WIDTH-1:0] clr;
  logic [WIDTH-1:0] impl;

  assign impl = IMPL[WIDTH-1:0];
  // writing zero clears, writing one keeps
  assign clr = (wr_en ? (wr_strb & ~wr_data) : '0); // see RULE12
  // set wins over clear, flags latch regardless of mask
  assign nxt_flags = ((flags_ff & ~clr) | live) & impl; // see RULE11 see RULE14
  assign flags = flags_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      flags_ff <= ffia_pkg::FLAG_RST[WIDTH-1:0];
    end else begin
      flags_ff <= nxt_flags;
    end
  end
endmodule : ffia_flag_bank

// *** design/ffia_top.sv ***
// module: fault flag interrupt aggregator with AXI4-Lite register slave
// What this block does
// RULE1: interrupt output low while any set flag has its mask bit clear.
// RULE2: every sticky flag has its own mask bit.
// RULE3: interrupt releases high once all set flags are written zero.
// RULE4: setting mask bits of all set flags releases interrupt; flags stay.
// RULE5: mask A bit 0 blocks the calibrating flag.
// RULE6: mask A bit 1 blocks the crystal input loss flag.
// RULE7: mask A bit 2 blocks the selected reference loss flag.
// RULE8: mask A bit 3 blocks the pll unlock flag.
// RULE9: mask A bit 5 blocks the bus timeout flag; bit 4 unused.
// RULE10: mask B bits 3..0 block feedback, input 2, 1, 0 loss flags.
// RULE11: a flag sets on its live status and holds until software clears.
// RULE12: writing zero clears a flag bit, writing one leaves it.
// RULE13: flags sit at bits 0,1,2,3,5 and next register bits 3..0.
// RULE14: flags latch while masked; unmasking a set flag reasserts next cycle.
`timescale 1ns/1ps
module ffia_top (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic CALIBRATING_STATUS,
  input wire logic XTAL_INPUT_LOS,
  input wire logic SELECTED_REF_LOS,
  input wire logic PLL_UNLOCKED,
  input wire logic BUS_TIMEOUT,
  input wire logic [3:0] PER_INPUT_LOS,
  input wire logic [ffia_pkg::ADDR_W-1:0] S_AWADDR,
  input wire logic S_AWVALID,
  output logic S_AWREADY,
  input wire logic [31:0] S_WDATA,
  input wire logic [3:0] S_WSTRB,
  input wire logic S_WVALID,
  output logic S_WREADY,
  output logic [1:0] S_BRESP,
  output logic S_BVALID,
  input wire logic S_BREADY,
  input wire logic [ffia_pkg::ADDR_W-1:0] S_ARADDR,
  input wire logic S_ARVALID,
  output logic S_ARREADY,
  output logic [31:0] S_RDATA,
  output logic [1:0] S_RRESP,
  output logic S_RVALID,
  input wire logic S_RREADY,
  output logic IRQ_OUT_N,
  output logic EVT_IRQ
);
  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic hit(input logic [ffia_pkg::ADDR_W-1:0] a, input logic [7:0] idx);
    hit = (a[ffia_pkg::ADDR_W-1:2] == idx);
  endfunction : hit

  function automatic logic known(input logic [ffia_pkg::ADDR_W-1:0] a);
    known = hit(a, ffia_pkg::IDX_LIVE_A) | hit(a, ffia_pkg::IDX_LIVE_B) |
            hit(a, ffia_pkg::IDX_FLAG_A) | hit(a, ffia_pkg::IDX_FLAG_B) |
            hit(a, ffia_pkg::IDX_MASK_A) | hit(a, ffia_pkg::IDX_MASK_B) |
            hit(a, ffia_pkg::IDX_EVT_STAT) | hit(a, ffia_pkg::IDX_EVT_CLR) |
            hit(a, ffia_pkg::IDX_EVT_EN);
  endfunction : known

  // ****************************************
  // write channel capture
  // ****************************************
  ffia_pkg::ffia_addr_t aw_ff;
  logic w_have_ff;
  logic [7:0] w_data_ff;
  logic w_strb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic wr_fire;
  logic wr_known;

  assign S_AWREADY = ~aw_ff.valid & ~bvalid_ff;
  assign S_WREADY = ~w_have_ff & ~bvalid_ff;
  assign wr_fire = aw_ff.valid & w_have_ff;
  assign wr_known = known(aw_ff.addr);
  assign S_BVALID = bvalid_ff;
  assign S_BRESP = bresp_ff;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      aw_ff <= '0;
      w_have_ff <= 1'b0;
      w_data_ff <= 8'h00;
      w_strb_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= ffia_pkg::RESP_OKAY;
    end else begin
      if (S_AWVALID && S_AWREADY) begin
        aw_ff <= '{valid: 1'b1, addr: S_AWADDR};
      end
      if (S_WVALID && S_WREADY) begin
        w_have_ff <= 1'b1;
        w_data_ff <= S_WDATA[7:0];
        w_strb_ff <= S_WSTRB[0];
      end
      if (wr_fire) begin
        aw_ff.valid <= 1'b0;
        w_have_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_known ? ffia_pkg::RESP_OKAY : ffia_pkg::RESP_SLVERR;
      end else if (bvalid_ff && S_BREADY) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // ****************************************
  // write strobes per register
  // ****************************************
  logic we_flag_a;
  logic we_flag_b;
  logic we_mask_a;
  logic we_mask_b;
  logic we_evt_clr;
  logic we_evt_en;
  logic [7:0] wstrb8;

  assign wstrb8 = {8{w_strb_ff}};
  assign we_flag_a = wr_fire & w_strb_ff & hit(aw_ff.addr, ffia_pkg::IDX_FLAG_A);
  assign we_flag_b = wr_fire & w_strb_ff & hit(aw_ff.addr, ffia_pkg::IDX_FLAG_B);
  assign we_mask_a = wr_fire & w_strb_ff & hit(aw_ff.addr, ffia_pkg::IDX_MASK_A);
  assign we_mask_b = wr_fire & w_strb_ff & hit(aw_ff.addr, ffia_pkg::IDX_MASK_B);
  assign we_evt_clr = wr_fire & w_strb_ff & hit(aw_ff.addr, ffia_pkg::IDX_EVT_CLR);
  assign we_evt_en = wr_fire & w_strb_ff & hit(aw_ff.addr, ffia_pkg::IDX_EVT_EN);

  // ****************************************
  // live status and sticky flags
  // ****************************************
  ffia_pkg::ffia_flags_t live;
  ffia_pkg::ffia_flags_t flags;

  // bit 4 of group a has no source
  assign live.grp_a = {2'b00, BUS_TIMEOUT, 1'b0, PLL_UNLOCKED, SELECTED_REF_LOS,
                       XTAL_INPUT_LOS, CALIBRATING_STATUS}; // see RULE13
  assign live.grp_b = {4'h0, PER_INPUT_LOS}; // see RULE13

  ffia_flag_bank #(.WIDTH(8), .IMPL(ffia_pkg::FLAG_A_BITS)) u_flags_a (
    .clk(CLK_SYS),
    .rst(RST),
    .live(live.grp_a),
    .wr_en(we_flag_a),
    .wr_data(w_data_ff),
    .wr_strb(wstrb8),
    .flags(flags.grp_a)
  ); // see RULE11 see RULE12
  ffia_flag_bank #(.WIDTH(8), .IMPL(ffia_pkg::FLAG_B_BITS)) u_flags_b (
    .clk(CLK_SYS),
    .rst(RST),
    .live(live.grp_b),
    .wr_en(we_flag_b),
    .wr_data(w_data_ff),
    .wr_strb(wstrb8),
    .flags(flags.grp_b)
  ); // see RULE11 see RULE12

  // ****************************************
  // mask registers
  // ****************************************
  ffia_pkg::ffia_flags_t mask_ff;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      mask_ff.grp_a <= ffia_pkg::MASK_A_RST;
      mask_ff.grp_b <= ffia_pkg::MASK_B_RST;
    end else begin
      if (we_mask_a) begin
        mask_ff.grp_a <= w_data_ff & ffia_pkg::FLAG_A_BITS; // see RULE2 see RULE9
      end
      if (we_mask_b) begin
        mask_ff.grp_b <= w_data_ff & ffia_pkg::FLAG_B_BITS; // see RULE10
      end
    end
  end

  // ****************************************
  // interrupt pin
  // ****************************************
  logic [7:0] pend_a;
  logic [7:0] pend_b;
  logic irq_n_ff;
  // one mask bit per flag position
  assign pend_a = flags.grp_a & ~mask_ff.grp_a; // see RULE5 see RULE6 see RULE7 see RULE8 see RULE9
  assign pend_b = flags.grp_b & ~mask_ff.grp_b; // see RULE10

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      irq_n_ff <= 1'b1;
    end else begin
      // low while any unmasked flag is set; released by clearing or masking
      irq_n_ff <= ~(|pend_a | |pend_b); // see RULE1 see RULE3 see RULE4 see RULE14
    end
  end
  assign IRQ_OUT_N = irq_n_ff;

  // ****************************************
  // event status: bit 0 interrupt assert edge, bit 1 bad write
  // ****************************************
  logic [1:0] evt_stat_ff;
  logic [1:0] evt_en_ff;
  logic [1:0] evt_set;
  logic irq_edge;

  assign irq_edge = irq_n_ff & (|pend_a | |pend_b);
  assign evt_set = {wr_fire & ~wr_known, irq_edge};

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      evt_stat_ff <= 2'b00;
      evt_en_ff <= 2'b00;
    end else begin
      evt_stat_ff <= (evt_stat_ff & ~(we_evt_clr ? w_data_ff[1:0] : 2'b00)) | evt_set;
      if (we_evt_en) begin
        evt_en_ff <= w_data_ff[1:0] & ffia_pkg::EVT_BITS;
      end
    end
  end
  assign EVT_IRQ = |(evt_stat_ff & evt_en_ff);

  // ****************************************
  // read channel
  // ****************************************
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic [7:0] rd_mux;

  assign S_ARREADY = ~rvalid_ff;
  assign S_RVALID = rvalid_ff;
  assign S_RDATA = rdata_ff;
  assign S_RRESP = rresp_ff;
  assign rd_mux =
    hit(S_ARADDR, ffia_pkg::IDX_LIVE_A) ? live.grp_a :
    hit(S_ARADDR, ffia_pkg::IDX_LIVE_B) ? live.grp_b :
    hit(S_ARADDR, ffia_pkg::IDX_FLAG_A) ? flags.grp_a :
    hit(S_ARADDR, ffia_pkg::IDX_FLAG_B) ? flags.grp_b :
    hit(S_ARADDR, ffia_pkg::IDX_MASK_A) ? mask_ff.grp_a :
    hit(S_ARADDR, ffia_pkg::IDX_MASK_B) ? mask_ff.grp_b :
    hit(S_ARADDR, ffia_pkg::IDX_EVT_STAT) ? {6'h00, evt_stat_ff} :
    hit(S_ARADDR, ffia_pkg::IDX_EVT_EN) ? {6'h00, evt_en_ff} : 8'h00;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= ffia_pkg::RESP_OKAY;
    end else if (S_ARVALID && S_ARREADY) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= {24'h00_0000, rd_mux};
      rresp_ff <= known(S_ARADDR) ? ffia_pkg::RESP_OKAY : ffia_pkg::RESP_SLVERR;
    end else if (rvalid_ff && S_RREADY) begin
      rvalid_ff <= 1'b0;
    end
  end
endmodule : ffia_top

// *** tb/ffia_props.sv ***
// checker: bus handshake and interrupt timing of ffia_top
`timescale 1ns/1ps
module ffia_props (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic S_AWVALID,
  input wire logic S_AWREADY,
  input wire logic S_WVALID,
  input wire logic S_WREADY,
  input wire logic [1:0] S_BRESP,
  input wire logic S_BVALID,
  input wire logic S_BREADY,
  input wire logic S_ARVALID,
  input wire logic S_ARREADY,
  input wire logic [31:0] S_RDATA,
  input wire logic S_RVALID,
  input wire logic S_RREADY,
  input wire logic IRQ_OUT_N
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  sequence wr_taken;
    S_AWVALID && S_AWREADY && S_WVALID && S_WREADY;
  endsequence
  sequence rd_taken;
    S_ARVALID && S_ARREADY;
  endsequence
  a_write_resp: assert property (wr_taken |-> ##[1:3] S_BVALID)
    else $error("write response missing");
  a_read_lat: assert property (rd_taken |=> S_RVALID)
    else $error("read data late");
  a_b_hold: assert property (S_BVALID && !S_BREADY |=> S_BVALID && $stable(S_BRESP))
    else $error("write response dropped");
  a_r_hold: assert property (S_RVALID && !S_RREADY |=> S_RVALID && $stable(S_RDATA))
    else $error("read data dropped");
  a_aw_block: assert property (S_BVALID |-> !S_AWREADY && !S_WREADY)
    else $error("write taken during response");
  a_ar_block: assert property (S_RVALID |-> !S_ARREADY)
    else $error("read taken during data");
  a_irq_reset: assert property (@(posedge CLK_SYS) disable iff (1'h0) RST |=> IRQ_OUT_N)
    else $error("interrupt low after reset");
  a_irq_sticky: assert property ($rose(IRQ_OUT_N) |-> $past(S_BVALID) || $past(S_BVALID, 2))
    else $error("interrupt released without write");
endmodule : ffia_props
bind ffia_top ffia_props u_props (.*);

// *** tb/ffia_top_test.sv ***
// testbench: registers, masks and sticky flags of ffia_top
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %s exp %h got %h", nm, e, g); end end
module ffia_top_test;
  // ****************************************
  // stimulus and checks
  // ****************************************
  logic CLK_SYS = 1'h0;
  logic RST = 1'h1;
  logic [8:0] live = 9'h0;
  logic CALIBRATING_STATUS, XTAL_INPUT_LOS, SELECTED_REF_LOS, PLL_UNLOCKED, BUS_TIMEOUT;
  logic [3:0] PER_INPUT_LOS;
  logic [9:0] S_AWADDR = 10'h0, S_ARADDR = 10'h0;
  logic [31:0] S_WDATA = 32'h0, S_RDATA;
  logic [33:0] got;
  logic [3:0] S_WSTRB = 4'h0;
  logic S_AWVALID = 1'h0, S_WVALID = 1'h0, S_BREADY = 1'h0, S_ARVALID = 1'h0, S_RREADY = 1'h0;
  logic S_AWREADY, S_WREADY, S_BVALID, S_ARREADY, S_RVALID, IRQ_OUT_N, EVT_IRQ;
  logic [1:0] S_BRESP, S_RRESP;
  logic [7:0] ia;
  logic [31:0] bm, ex;
  logic [31:0] seed = 32'h0000704e;
  logic [33:0] exp_q[$];
  int failures = 0, n_checks = 0;
  assign {PER_INPUT_LOS, BUS_TIMEOUT, PLL_UNLOCKED, SELECTED_REF_LOS, XTAL_INPUT_LOS,
    CALIBRATING_STATUS} = live;
  always #2 CLK_SYS = ~CLK_SYS;
  ffia_top DUT (.*);
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic [9:0] ba(input logic [7:0] idx);
    return {idx, 2'h0};
  endfunction : ba
  task automatic tick(input int n);
    repeat (n) @(posedge CLK_SYS);
  endtask : tick
  task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [1:0] r);
    logic da, dw, g;
    da = 1'h0;
    dw = 1'h0;
    @(posedge CLK_SYS);
    S_AWADDR <= a;
    S_WDATA <= d;
    S_WSTRB <= 4'hf;
    S_AWVALID <= 1'h1;
    S_WVALID <= 1'h1;
    do begin
      @(negedge CLK_SYS);
      da = da | S_AWREADY;
      dw = dw | S_WREADY;
      @(posedge CLK_SYS);
      if (da) S_AWVALID <= 1'h0;
      if (dw) S_WVALID <= 1'h0;
    end while (!(da && dw));
    tick(2);
    S_BREADY <= 1'h1;
    do begin
      @(negedge CLK_SYS);
      g = S_BVALID;
      if (g) `CHK("bresp", r, S_BRESP)
      @(posedge CLK_SYS);
    end while (!g);
    S_BREADY <= 1'h0;
  endtask : wr
  task automatic rd(input logic [9:0] a, input logic [31:0] e, input logic [1:0] r);
    logic g;
    @(posedge CLK_SYS);
    exp_q.push_back({r, e});
    S_ARADDR <= a;
    S_ARVALID <= 1'h1;
    do begin
      @(negedge CLK_SYS);
      g = S_ARREADY;
      @(posedge CLK_SYS);
    end while (!g);
    S_ARVALID <= 1'h0;
    tick(1);
    S_RREADY <= 1'h1;
    do begin
      @(negedge CLK_SYS);
      g = S_RVALID;
      @(posedge CLK_SYS);
    end while (!g);
    S_RREADY <= 1'h0;
  endtask : rd
  task automatic give_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  always @(negedge CLK_SYS) begin
    if (S_RVALID && S_RREADY) begin
      got = exp_q.pop_front();
      `CHK("rdata", got, {S_RRESP, S_RDATA})
    end
  end
  initial begin
    tick(30000);
    failures++;
    give_verdict();
  end
  initial begin
    tick(20);
    RST <= 1'h0;
    tick(1);
    @(negedge CLK_SYS);
    `CHK("irq_n", 1'h1, IRQ_OUT_N)
    rd(ba(ffia_pkg::IDX_MASK_A), {24'h0, ffia_pkg::MASK_A_RST}, ffia_pkg::RESP_OKAY);
    rd(ba(ffia_pkg::IDX_MASK_B), {24'h0, ffia_pkg::MASK_B_RST}, ffia_pkg::RESP_OKAY);
    rd(ba(ffia_pkg::IDX_FLAG_A), {24'h0, ffia_pkg::FLAG_RST}, ffia_pkg::RESP_OKAY);
    wr(ba(ffia_pkg::IDX_EVT_EN), 32'h1, ffia_pkg::RESP_OKAY);
    for (int i = 0; i < 9; i++) begin
      ia = (i < 5) ? ffia_pkg::IDX_FLAG_A : ffia_pkg::IDX_FLAG_B;
      bm = (i < 4) ? 32'h1 << i : (i == 4) ? 32'h20 : 32'h1 << (i - 5);
      wr(ba(ia + 8'h06), bm, ffia_pkg::RESP_OKAY);
      live[i] <= 1'h1;
      tick(1);
      live[i] <= 1'h0;
      tick(3);
      @(negedge CLK_SYS);
      `CHK("irq_n masked", 1'h1, IRQ_OUT_N)
      rd(ba(ia), bm, ffia_pkg::RESP_OKAY);
      wr(ba(ia + 8'h06), 32'h0, ffia_pkg::RESP_OKAY);
      tick(2);
      @(negedge CLK_SYS);
      `CHK("irq_n unmasked", 1'h0, IRQ_OUT_N)
      wr(ba(ia), xs() | bm, ffia_pkg::RESP_OKAY);
      tick(2);
      @(negedge CLK_SYS);
      `CHK("irq_n write one", 1'h0, IRQ_OUT_N)
      wr(ba(ia), ~bm, ffia_pkg::RESP_OKAY);
      tick(2);
      @(negedge CLK_SYS);
      `CHK("irq_n cleared", 1'h1, IRQ_OUT_N)
      rd(ba(ia), 32'h0, ffia_pkg::RESP_OKAY);
    end
    @(negedge CLK_SYS);
    `CHK("evt_irq", 1'h1, EVT_IRQ)
    wr(ba(ffia_pkg::IDX_EVT_CLR), 32'h3, ffia_pkg::RESP_OKAY);
    wr(10'h3fc, 32'h1, ffia_pkg::RESP_SLVERR);
    tick(2);
    @(negedge CLK_SYS);
    `CHK("evt_irq masked", 1'h0, EVT_IRQ)
    rd(ba(ffia_pkg::IDX_EVT_STAT), 32'h2, ffia_pkg::RESP_OKAY);
    rd(10'h3fc, 32'h0, ffia_pkg::RESP_SLVERR);
    live <= 9'h021;
    tick(1);
    live <= 9'h0;
    tick(3);
    @(negedge CLK_SYS);
    `CHK("irq_n two", 1'h0, IRQ_OUT_N)
    wr(ba(ffia_pkg::IDX_MASK_A), 32'hff, ffia_pkg::RESP_OKAY);
    tick(2);
    @(negedge CLK_SYS);
    `CHK("irq_n half", 1'h0, IRQ_OUT_N)
    wr(ba(ffia_pkg::IDX_MASK_B), 32'hff, ffia_pkg::RESP_OKAY);
    tick(2);
    @(negedge CLK_SYS);
    `CHK("irq_n all masked", 1'h1, IRQ_OUT_N)
    ex = {24'h0, ffia_pkg::FLAG_A_BITS};
    rd(ba(ffia_pkg::IDX_MASK_A), ex, ffia_pkg::RESP_OKAY);
    ex = {24'h0, ffia_pkg::FLAG_B_BITS};
    rd(ba(ffia_pkg::IDX_MASK_B), ex, ffia_pkg::RESP_OKAY);
    rd(ba(ffia_pkg::IDX_FLAG_A), 32'h1, ffia_pkg::RESP_OKAY);
    rd(ba(ffia_pkg::IDX_FLAG_B), 32'h1, ffia_pkg::RESP_OKAY);
    give_verdict();
  end
endmodule : ffia_top_test
